// File: rtl/epp_cycle_engine.sv
`timescale 1ns/1ns
module epp_cycle_engine (
    input  wire logic                  i_core_clk,
    input  wire logic                  i_rst,
    input  wire epp_pkg::epp_apb_req_t i_apb,
    input  wire logic [7:0]            i_port_in,
    input  wire logic                  i_periph_hold_n,
    input  wire logic                  i_periph_irq_in,
    output epp_pkg::epp_apb_rsp_t      o_apb,
    output epp_pkg::epp_pins_t         o_pins
);
    import epp_pkg::*;

    // all engine state
    typedef struct packed {
        epp_state_t   st;
        epp_mode_t    mode;
        epp_mode_t    cyc_mode;
        logic [5:0]   ctrl;
        logic [7:0]   port_byte;
        logic         tmo;
        logic         write;
        logic         addr;
        epp_apb_rsp_t rsp;
        epp_cyc_t     cyc;
    } epp_core_t;

    epp_core_t s;
    epp_core_t next_s;
    logic      acc;
    logic      is_eaddr;
    logic      is_epp;
    logic      wd_expired;
    logic [7:0] stat;

    // address decode of the epp address and data registers
    assign is_eaddr = (i_apb.paddr == REG_EADDR);
    assign is_epp   = is_eaddr ||
                      ((i_apb.paddr >= REG_EDATA0) &&
                       (i_apb.paddr <= REG_EDATA3) &&
                       (i_apb.paddr[1:0] == 2'b00));

    // status word as software sees it
    always_comb begin
        stat          = 8'h00;
        stat[ST_TMO]  = s.tmo;
        stat[ST_HOLD] = i_periph_hold_n;
        stat[ST_IRQ]  = i_periph_irq_in;
        stat[ST_BUSY] = (s.st != S_IDLE);
    end

    // watchdog runs from request start to cycle end
    epp_watchdog #(
        .CYCLES (TMO_CYCLES)
    ) u_wd (
        .i_core_clk (i_core_clk),
        .i_rst      (i_rst),
        .i_run      (s.st != S_IDLE),
        .o_expired  (wd_expired)
    );

    // next state of the cycle engine and register file
    always_comb begin
        next_s             = s;
        acc                = i_apb.psel && i_apb.penable && !s.rsp.pready;
        next_s.rsp.pready  = 1'b0;
        next_s.rsp.pslverr = 1'b0;
        case (s.st)
            S_IDLE: begin
                if (acc && is_epp && (s.mode != MODE_SPP)) begin
                    // host access to an epp port opens a cycle
                    next_s.cyc_mode = s.mode;
                    next_s.addr     = is_eaddr;
                    if (s.mode == MODE_EPP19) begin
                        // direction bit turns writes into reads
                        next_s.write = i_apb.pwrite && !s.ctrl[CTL_DIR];
                        next_s.st    = S_ARM;
                    end else begin
                        next_s.write = i_apb.pwrite;
                        next_s.st    = S_SET;
                    end
                    if (i_apb.pwrite) begin
                        next_s.port_byte = i_apb.pwdata[7:0];
                    end
                end else if (acc) begin
                    // plain register access, answered next cycle
                    next_s.rsp.pready = 1'b1;
                    next_s.rsp.prdata = 32'h0000_0000;
                    case (i_apb.paddr)
                        REG_DATA: begin
                            if (i_apb.pwrite) begin
                                next_s.port_byte = i_apb.pwdata[7:0];
                            end else if (s.ctrl[CTL_DIR] &&
                                         s.mode != MODE_SPP) begin
                                next_s.rsp.prdata[7:0] = i_port_in;
                            end else begin
                                next_s.rsp.prdata[7:0] = s.port_byte;
                            end
                        end
                        REG_STAT: begin
                            if (i_apb.pwrite && i_apb.pwdata[ST_TMO]) begin
                                next_s.tmo = 1'b0;
                            end
                            next_s.rsp.prdata[7:0] = stat;
                        end
                        REG_CTRL: begin
                            if (i_apb.pwrite) begin
                                next_s.ctrl = i_apb.pwdata[5:0];
                            end
                            next_s.rsp.prdata[5:0] = s.ctrl;
                        end
                        REG_MODE: begin
                            if (i_apb.pwrite) begin
                                case (i_apb.pwdata[1:0])
                                    2'h1:    next_s.mode = MODE_EPP19;
                                    2'h2:    next_s.mode = MODE_EPP17;
                                    default: next_s.mode = MODE_SPP;
                                endcase
                            end
                            next_s.rsp.prdata[1:0] = s.mode;
                        end
                        default: begin
                            // unmapped, or epp port while in spp mode
                            next_s.rsp.pslverr = 1'b1;
                        end
                    endcase
                end
            end
            S_ARM: begin
                // pins stay put until the peripheral shows ready
                if (!i_periph_hold_n) begin
                    next_s.st = S_SET;
                end
            end
            S_SET: begin
                // bus turned and direction valid before strobe
                next_s.st = S_STB;
            end
            S_STB: begin
                if (s.cyc_mode == MODE_EPP19) begin
                    // finish only once hold has gone high
                    if (i_periph_hold_n) begin
                        next_s.rsp.prdata = {24'h00_0000, i_port_in};
                        next_s.st         = S_END;
                    end
                end else if (s.rsp.pready) begin
                    // host ends its access at this edge
                    next_s.st = S_END;
                end else if (i_periph_hold_n) begin
                    // release the host once hold is high
                    next_s.rsp.pready = 1'b1;
                    if (!s.write) begin
                        next_s.rsp.prdata = {24'h00_0000, i_port_in};
                    end
                end
            end
            S_END: begin
                // strobe is already off; 1.9 answers now
                if (s.cyc_mode == MODE_EPP19) begin
                    next_s.rsp.pready = 1'b1;
                end
                next_s.st = S_IDLE;
            end
            default: begin
                next_s.st = S_IDLE;
            end
        endcase

        // time-out aborts and answers with an error, set wins over clear
        if (wd_expired) begin
            next_s.st          = S_IDLE;
            next_s.rsp.pready  = 1'b1;
            next_s.rsp.pslverr = 1'b1;
            next_s.tmo         = 1'b1;
        end

        // cycle view handed to the pin driver
        next_s.cyc.active   = (next_s.st != S_IDLE);
        next_s.cyc.write    = next_s.write;
        next_s.cyc.hold     = (next_s.st == S_ARM);
        next_s.cyc.data_sel = (next_s.st == S_STB) && !next_s.addr;
        next_s.cyc.addr_sel = (next_s.st == S_STB) && next_s.addr;
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            s      <= '0;
            s.ctrl <= CTRL_RST;
        end else begin
            s <= next_s;
        end
    end

    // registered pin driver sees the cycle aligned with the state
    epp_pin_drv u_pins (
        .i_core_clk (i_core_clk),
        .i_rst      (i_rst),
        .i_mode     (s.mode),
        .i_ctrl     (next_s.ctrl),
        .i_cyc      (next_s.cyc),
        .i_byte     (next_s.port_byte),
        .i_irq      (i_periph_irq_in),
        .o_pins     (o_pins)
    );

    assign o_apb = s.rsp;

    // ---- checks ----
    sequence seq_strobe_off;
        o_pins.data_select_n && o_pins.addr_select_n;
    endsequence

    sequence seq_answer_19;
        s.st == S_END ##1 (o_apb.pready && !o_apb.pslverr);
    endsequence

    AST_RDY_LOW_19: assert property (@(posedge i_core_clk)
        disable iff (i_rst)
        (s.cyc_mode == MODE_EPP19 &&
         (s.st == S_ARM || s.st == S_SET || s.st == S_STB))
        |-> !o_apb.pready)
        else $error("pready high during 1.9 cycle");

    AST_WAIT_LOW: assert property (@(posedge i_core_clk)
        disable iff (i_rst)
        (s.st == S_ARM && i_periph_hold_n && !wd_expired)
        |=> (s.st == S_ARM && !o_pins.data_select_n == 1'b0))
        else $error("left arm state while hold high");

    AST_READ_DONE_19: assert property (@(posedge i_core_clk)
        disable iff (i_rst)
        (s.st == S_STB && s.cyc_mode == MODE_EPP19 &&
         i_periph_hold_n && !wd_expired)
        |=> seq_strobe_off ##0 seq_answer_19)
        else $error("1.9 termination out of order");

    AST_READ_DATA_19: assert property (@(posedge i_core_clk)
        disable iff (i_rst)
        (s.st == S_STB && s.cyc_mode == MODE_EPP19 && !s.write &&
         i_periph_hold_n && !wd_expired)
        |=> ##1 o_apb.prdata[7:0] == $past(i_port_in, 2))
        else $error("1.9 read byte not captured");

    AST_HOLD_17: assert property (@(posedge i_core_clk)
        disable iff (i_rst)
        (s.st == S_STB && s.cyc_mode == MODE_EPP17 &&
         !i_periph_hold_n && !s.rsp.pready && !wd_expired)
        |=> !o_apb.pready)
        else $error("1.7 pready while hold low");

    AST_END_17: assert property (@(posedge i_core_clk)
        disable iff (i_rst)
        (s.st == S_STB && s.cyc_mode == MODE_EPP17 && o_apb.pready)
        |=> seq_strobe_off ##1 s.st == S_IDLE)
        else $error("1.7 strobe not dropped at host end");

    AST_TMO_ABORT: assert property (@(posedge i_core_clk)
        disable iff (i_rst)
        wd_expired |=> (s.tmo && s.st == S_IDLE &&
                        o_pins.data_select_n && o_pins.addr_select_n &&
                        o_apb.pready && o_apb.pslverr))
        else $error("time-out did not abort the cycle");

    AST_TMO_STICKY: assert property (@(posedge i_core_clk)
        disable iff (i_rst)
        (s.tmo && !(acc && i_apb.pwrite && i_apb.paddr == REG_STAT &&
                    i_apb.pwdata[ST_TMO]))
        |=> s.tmo)
        else $error("time-out flag lost");

    AST_WRITE_BYTE: assert property (@(posedge i_core_clk)
        disable iff (i_rst)
        (s.st == S_STB && s.write && s.cyc_mode == MODE_EPP17 &&
         !s.ctrl[CTL_DIR])
        |-> (o_pins.port_oe && o_pins.port_out == s.port_byte))
        else $error("write byte not on port bus");
endmodule : epp_cycle_engine

// File: rtl/epp_pin_drv.sv
`timescale 1ns/1ns
module epp_pin_drv (
    input  wire logic                i_core_clk,
    input  wire logic                i_rst,
    input  wire epp_pkg::epp_mode_t  i_mode,
    input  wire logic [5:0]          i_ctrl,
    input  wire epp_pkg::epp_cyc_t   i_cyc,
    input  wire logic [7:0]          i_byte,
    input  wire logic                i_irq,
    output epp_pkg::epp_pins_t       o_pins
);
    import epp_pkg::*;

    epp_pins_t s;
    epp_pins_t next_s;
    logic      wr;

    // pin levels for idle port and for running cycles
    always_comb begin
        next_s          = s;
        wr              = 1'b0;
        next_s.port_out = i_byte;
        next_s.reset_n  = i_ctrl[CTL_INIT];
        next_s.irq      = i_irq;
        if (!i_cyc.active) begin
            // idle port follows the control register
            next_s.data_select_n = ~i_ctrl[CTL_AFD];
            next_s.addr_select_n = ~i_ctrl[CTL_SLIN];
            next_s.port_oe = (i_mode == MODE_SPP) || !i_ctrl[CTL_DIR];
            if (i_mode == MODE_EPP17) begin
                next_s.write_dir_n = i_ctrl[CTL_DIR] && !i_ctrl[CTL_STB];
            end else begin
                next_s.write_dir_n = ~i_ctrl[CTL_STB];
            end
        end else if (!i_cyc.hold) begin
            next_s.data_select_n = ~i_cyc.data_sel;
            next_s.addr_select_n = ~i_cyc.addr_sel;
            if (i_mode == MODE_EPP17) begin
                wr = !i_ctrl[CTL_DIR] || i_ctrl[CTL_STB];
            end else begin
                wr = i_cyc.write || i_ctrl[CTL_STB];
            end
            next_s.write_dir_n = !wr;
            next_s.port_oe     = wr;
        end
        next_s.port_dir_out = !next_s.port_oe;
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            s <= '{port_out: 8'h00, port_oe: 1'b1, port_dir_out: 1'b0,
                   write_dir_n: 1'b1, data_select_n: 1'b1,
                   addr_select_n: 1'b1, reset_n: 1'b0, irq: 1'b0};
        end else begin
            s <= next_s;
        end
    end

    assign o_pins = s;

    AST_STB_OVERRIDE: assert property (@(posedge i_core_clk)
        disable iff (i_rst)
        (i_cyc.active && !i_cyc.hold && i_ctrl[CTL_STB])
        |=> (!o_pins.write_dir_n && o_pins.port_oe))
        else $error("strobe bit did not force write mode");
    AST_IRQ_PASS: assert property (@(posedge i_core_clk)
        disable iff (i_rst)
        ##1 o_pins.irq == $past(i_irq))
        else $error("interrupt not passed through");
endmodule : epp_pin_drv

// File: rtl/epp_watchdog.sv
`timescale 1ns/1ns
module epp_watchdog #(
    parameter int unsigned CYCLES = epp_pkg::TMO_CYCLES
) (
    input  wire logic i_core_clk,
    input  wire logic i_rst,
    input  wire logic i_run,
    output logic      o_expired
);
    import epp_pkg::*;
    localparam int unsigned CW = $clog2(CYCLES + 1);

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic          exp;
    } epp_wd_t;

    epp_wd_t s;
    epp_wd_t next_s;

    // count while a cycle runs, pulse once at the limit
    always_comb begin
        next_s     = s;
        next_s.exp = i_run && (s.cnt == CW'(CYCLES - 1));
        next_s.cnt = i_run ? s.cnt + CW'(1) : '0;
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign o_expired = s.exp;

    AST_WD_LIMIT: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (i_run && s.cnt == CW'(CYCLES - 1)) |=> o_expired)
        else $error("watchdog missed its limit");
endmodule : epp_watchdog

// File: shared/epp_pkg.sv
package epp_pkg;
    // clock and watchdog timing
    localparam int unsigned CLK_MHZ     = 100;
    localparam int unsigned TMO_NS      = 10000;
    localparam int unsigned TMO_CYCLES  = TMO_NS * CLK_MHZ / 1000;
    // register byte offsets
    localparam logic [7:0] REG_DATA   = 8'h00;
    localparam logic [7:0] REG_STAT   = 8'h04;
    localparam logic [7:0] REG_CTRL   = 8'h08;
    localparam logic [7:0] REG_EADDR  = 8'h0C;
    localparam logic [7:0] REG_EDATA0 = 8'h10;
    localparam logic [7:0] REG_EDATA3 = 8'h1C;
    localparam logic [7:0] REG_MODE   = 8'h20;
    // control register fields
    localparam int unsigned CTL_STB   = 0;
    localparam int unsigned CTL_AFD   = 1;
    localparam int unsigned CTL_INIT  = 2;
    localparam int unsigned CTL_SLIN  = 3;
    localparam int unsigned CTL_IRQE  = 4;
    localparam int unsigned CTL_DIR   = 5;
    localparam logic [5:0]  CTRL_RST  = 6'h00;
    // status register fields
    localparam int unsigned ST_TMO    = 0;
    localparam int unsigned ST_HOLD   = 1;
    localparam int unsigned ST_IRQ    = 2;
    localparam int unsigned ST_BUSY   = 3;

    typedef enum logic [1:0] {
        MODE_SPP   = 2'h0,
        MODE_EPP19 = 2'h1,
        MODE_EPP17 = 2'h2
    } epp_mode_t;

    // gray along idle, arm, setup, strobe, end
    typedef enum logic [2:0] {
        S_IDLE = 3'h0,
        S_ARM  = 3'h1,
        S_SET  = 3'h3,
        S_STB  = 3'h2,
        S_END  = 3'h6
    } epp_state_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } epp_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } epp_apb_rsp_t;

    typedef struct packed {
        logic active;
        logic write;
        logic data_sel;
        logic addr_sel;
        logic hold;
    } epp_cyc_t;

    typedef struct packed {
        logic [7:0] port_out;
        logic       port_oe;
        logic       port_dir_out;
        logic       write_dir_n;
        logic       data_select_n;
        logic       addr_select_n;
        logic       reset_n;
        logic       irq;
    } epp_pins_t;
endpackage : epp_pkg

// File: verification/epp_periph_model.sv
`timescale 1ns/1ns
// behavioural parallel peripheral answering strobes after a set delay
module epp_periph_model (
    input  wire logic               i_core_clk,
    input  wire epp_pkg::epp_pins_t i_pins,
    input  wire logic [7:0]         i_reply,
    input  wire logic [3:0]         i_delay,
    input  wire logic               i_stuck,
    input  wire logic               i_lazy,
    output logic                    o_hold_n,
    output logic [7:0]              o_data,
    output logic [7:0]              o_latched
);
    import epp_pkg::*;
    logic       strobe;
    logic       drive   = 1'b0;
    logic [3:0] cnt     = 4'h0;
    logic [7:0] last    = 8'h00;

    initial o_hold_n = 1'b0;
    initial o_latched = 8'h00;
    assign strobe = !i_pins.data_select_n || !i_pins.addr_select_n;
    // a floated bus shows the inverse of the last byte, never a stale copy
    assign o_data = drive ? last : ~last;

    // count strobe cycles, then supply or latch the byte and acknowledge
    always @(posedge i_core_clk) begin
        if (!strobe) begin
            drive    <= 1'b0;
            o_hold_n <= i_lazy;
            cnt      <= 4'h0;
        end else if (cnt != 4'hF) begin
            cnt <= cnt + 4'h1;
            if (cnt == i_delay && !i_stuck) begin
                if (i_pins.write_dir_n) begin
                    drive <= 1'b1;
                    last  <= i_reply;
                end else begin
                    o_latched <= i_pins.port_out;
                    o_hold_n  <= 1'b1;
                end
            end
            if (cnt == i_delay + 4'h1 && !i_stuck && i_pins.write_dir_n)
                o_hold_n <= 1'b1;
        end
    end
endmodule : epp_periph_model

// File: verification/tb_epp_cycle_engine.sv
`timescale 1ns/1ns
// self-checking bench: apb master, peripheral model, pin monitor
module tb_epp_cycle_engine;
    import epp_pkg::*;
    logic         clk = 1'b0;
    logic         rst;
    epp_apb_req_t req;
    epp_apb_rsp_t rsp;
    epp_pins_t    pins;
    logic [7:0]   port_in, m_data, latched, reply;
    logic [3:0]   delay;
    logic         hold_n, irq_in, stuck, lazy, rd_err, chk_rd;
    logic         seen_d, seen_a, bad_rd, dir_hi;
    logic [31:0]  rd_data;
    int           cyc, n_errors = 0, num_checks = 0;
    logic [7:0]   t_addr [3] = '{REG_EDATA0, REG_EADDR, REG_EDATA3};
    logic [7:0]   t_byte [3] = '{8'hA5, 8'h3C, 8'hC3};
    logic [3:0]   t_dly  [3] = '{4'h0, 4'h5, 4'h9};

    always #5 clk = ~clk;
    // wire level of the shared byte lanes
    assign port_in = pins.port_oe ? pins.port_out : m_data;

    epp_cycle_engine dut (.i_core_clk(clk), .i_rst(rst), .i_apb(req),
        .i_port_in(port_in), .i_periph_hold_n(hold_n),
        .i_periph_irq_in(irq_in), .o_apb(rsp), .o_pins(pins));
    epp_periph_model peer (.i_core_clk(clk), .i_pins(pins),
        .i_reply(reply), .i_delay(delay), .i_stuck(stuck), .i_lazy(lazy),
        .o_hold_n(hold_n), .o_data(m_data), .o_latched(latched));

    // record strobe use and read-direction pins
    always @(negedge clk) begin
        if (pins.data_select_n === 1'b0) seen_d = 1'b1;
        if (pins.addr_select_n === 1'b0) seen_a = 1'b1;
        if (pins.port_dir_out === 1'b1) dir_hi = 1'b1;
        if (chk_rd && (!pins.data_select_n || !pins.addr_select_n) &&
            (pins.port_oe !== 1'b0 || pins.port_dir_out !== 1'b1 ||
             pins.write_dir_n !== 1'b1)) bad_rd = 1'b1;
    end

    task clr_mon;
        seen_d = 1'b0;
        seen_a = 1'b0;
        bad_rd = 1'b0;
        dir_hi = 1'b0;
    endtask : clr_mon

    task final_report;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : final_report

    task chk_val(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_val

    task chk_bit(input string nm, input logic e, input logic g);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("ERROR %s expected %b seen %b", nm, e, g);
        end
    endtask : chk_bit

    // one apb transfer held until pready is seen high
    task apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
        @(posedge clk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr,
                 pwdata: wd};
        @(posedge clk);
        req.penable <= 1'b1;
        cyc = 0;
        @(negedge clk);
        while (rsp.pready !== 1'b1 && cyc <= 3000) begin
            cyc++;
            @(negedge clk);
        end
        if (cyc > 3000) begin
            n_errors++;
            $display("ERROR pready expected 1 seen timeout");
            final_report();
        end
        rd_data = rsp.prdata;
        rd_err  = rsp.pslverr;
        @(posedge clk);
        req <= '0;
    endtask : apb

    task wr(input logic [7:0] addr, input logic [31:0] wd);
        apb(1'b1, addr, wd);
    endtask : wr

    task rd(input logic [7:0] addr);
        apb(1'b0, addr, 32'h0000_0000);
    endtask : rd

    // main sequence
    initial begin
        req = '0; rst = 1'b1; irq_in = 1'b0; reply = 8'h00;
        delay = 4'h0; stuck = 1'b0; lazy = 1'b0; chk_rd = 1'b0;
        clr_mon();
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(negedge clk);
        chk_val("idle_pins", 32'h0000_000E, {28'h0, pins.write_dir_n,
            pins.data_select_n, pins.addr_select_n, pins.reset_n});
        chk_bit("dir_out", 1'b0, pins.port_dir_out);
        rd(8'h30);
        chk_bit("unmapped_err", 1'b1, rd_err);
        rd(REG_EDATA0);
        chk_bit("spp_port_err", 1'b1, rd_err);
        wr(REG_CTRL, 32'h0000_000F);
        @(negedge clk);
        chk_val("ctrl_pins", 32'h0000_0001, {28'h0, pins.write_dir_n,
            pins.data_select_n, pins.addr_select_n, pins.reset_n});
        wr(REG_CTRL, 32'h0000_0004); // clear D0 D1 D3 and direction
        rd(REG_CTRL);
        chk_val("ctrl", 32'h0000_0004, rd_data);
        wr(REG_MODE, 32'h0000_0001);
        chk_rd = 1'b1;
        for (int i = 0; i < 3; i++) begin
            clr_mon();
            reply <= t_byte[i];
            delay <= t_dly[i];
            rd(t_addr[i]);
            chk_val("rd19_data", {24'h0, t_byte[i]}, rd_data);
            chk_bit("rd19_err", 1'b0, rd_err);
            chk_bit("rd19_wait", 1'b1, cyc > t_dly[i]);
            chk_bit("addr_sel", t_addr[i] == REG_EADDR, seen_a);
            chk_bit("data_sel", t_addr[i] != REG_EADDR, seen_d);
            chk_bit("rd19_pins", 1'b0, bad_rd);
        end
        lazy <= 1'b1;
        reply <= 8'h69;
        repeat (3) @(posedge clk);
        clr_mon();
        fork
            rd(REG_EDATA0);
            begin
                repeat (10) @(negedge clk);
                chk_bit("early_strobe", 1'b0, seen_d);
                @(posedge clk);
                lazy <= 1'b0;
            end
        join
        chk_val("lazy_data", 32'h0000_0069, rd_data);
        chk_rd = 1'b0;
        wr(REG_CTRL, 32'h0000_0005);
        clr_mon();
        rd(REG_EDATA0);
        chk_bit("forced_write", 1'b0, dir_hi);
        wr(REG_CTRL, 32'h0000_0004);
        wr(REG_MODE, 32'h0000_0002);
        clr_mon();
        delay <= 4'h3;
        wr(REG_EDATA0, 32'h0000_005A);
        chk_val("wr17_byte", 32'h0000_005A, {24'h0, latched});
        chk_bit("wr17_sel", 1'b1, seen_d);
        @(negedge clk);
        chk_bit("wr17_keep", 1'b1, pins.port_oe === 1'b1 &&
            pins.port_out === 8'h5A && pins.data_select_n === 1'b1);
        chk_bit("wr17_dir", 1'b0, pins.write_dir_n);
        wr(REG_CTRL, 32'h0000_0024); // direction set for reads
        @(negedge clk);
        chk_val("rd17_pins", 32'h0000_0003, {29'h0, pins.port_oe,
            pins.port_dir_out, pins.write_dir_n});
        clr_mon();
        chk_rd = 1'b1;
        reply <= 8'h96;
        delay <= 4'h6;
        rd(REG_EDATA0);
        chk_val("rd17_data", 32'h0000_0096, rd_data);
        chk_bit("rd17_wait", 1'b1, cyc > 6);
        chk_bit("rd17_pins", 1'b0, bad_rd);
        @(negedge clk);
        chk_bit("rd17_end", 1'b1, pins.data_select_n);
        @(posedge clk);
        stuck <= 1'b1;
        rd(REG_EDATA0);
        chk_bit("tmo_err", 1'b1, rd_err);
        chk_bit("tmo_time", 1'b1, cyc >= 990 && cyc <= 1010);
        @(negedge clk);
        chk_bit("tmo_sel", 1'b1, pins.data_select_n & pins.addr_select_n);
        @(posedge clk);
        stuck <= 1'b0;
        rd(REG_STAT);
        chk_bit("tmo_flag", 1'b1, rd_data[ST_TMO]);
        wr(REG_STAT, 32'h0000_0001);
        rd(REG_STAT);
        chk_bit("tmo_clear", 1'b0, rd_data[ST_TMO]);
        for (int v = 1; v >= 0; v--) begin
            @(posedge clk);
            irq_in <= v[0];
            repeat (3) @(posedge clk);
            @(negedge clk);
            chk_bit("irq_pin", v[0], pins.irq);
        end
        final_report();
    end
endmodule : tb_epp_cycle_engine
